// [design/ppm_ctrl.sv]
// Purpose: parallel port mode control, master and slave signalling
// Assumes: pins synchronous to clk_i, strobes active high
// Notes: registers reached over AXI4-Lite
// Notes on behaviour
// - busy flag reads one during master transfer
// - irq mode 01 interrupts at cycle end
// - irq mode 10 interrupts on buffer three
// - irq mode 00 silent; 11 reserved
// - step 01 increments address 10:2 and 14
// - step 10 decrements address 10:2 and 14
// - step 11 legacy slave advances buffer pointers
// - step 00 leaves address unchanged
// - bit 14 frozen when used as chip select
// - mode 11: direction strobe plus enable strobe
// - mode 10: separate read and write strobes
// - mode 01: addressed slave, two address bits
// - mode 00: legacy slave, no address
// - setup wait is field plus one clocks
// - strobe lasts strobe field plus one clocks
// - strobe field zero forces setup and hold
// - upper half and bit 10 read zero
`timescale 1ns/1ps
`default_nettype none
`include "ppm_defs.svh"
module ppm_ctrl (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [`PPM_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`PPM_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire ppm_pkg::ppm_host_t host_i,
    input wire logic [7:0] port_data_bus_i,
    output logic [7:0] port_data_bus_o,
    output logic port_data_bus_oe_o,
    output logic [14:0] port_address_lines_o,
    output logic chip_select_one_o,
    output logic read_strobe_o,
    output logic write_strobe_o,
    output logic enable_strobe_o,
    output logic irq_o
);
    logic rst_s1, rst_n;
    logic aw_got, w_got;
    logic [`PPM_AW-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [15:0] mode_q;
    logic a14_cs, is_rd, acc_prev, last_rd;
    logic [7:0] wr_data, rd_data;
    logic [1:0] stat, mask, rd_ptr, wr_ptr;
    logic [3:0] cnt;
    logic [7:0] obuf [4];
    logic [7:0] ibuf [4];
    ppm_pkg::ppm_state_t state, next_state;
    logic [3:0] next_cnt;
    logic done;

    // reset release through two flops
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // field view of the mode register
    ppm_pkg::ppm_mode_t m;
    assign m = ppm_pkg::ppm_mode_t'(mode_q[14:0]);
    wire master = m.port_mode[1];
    wire busy = (state != ppm_pkg::PPM_IDLE);

    // write decode once address and data both held
    wire wr_go = aw_got & w_got & ~s_axi_bvalid;
    wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                         {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire w_mode = wr_go & (awaddr_q == `PPM_OFF_MODE);
    wire w_addr = wr_go & (awaddr_q == `PPM_OFF_ADDR);
    wire w_data = wr_go & (awaddr_q == `PPM_OFF_DATA);
    wire w_ctrl = wr_go & (awaddr_q == `PPM_OFF_CTRL);
    wire w_stat = wr_go & (awaddr_q == `PPM_OFF_STAT);
    wire w_mask = wr_go & (awaddr_q == `PPM_OFF_MASK);
    wire w_obuf = wr_go & (awaddr_q == `PPM_OFF_OBUF);
    wire w_ibuf = wr_go & (awaddr_q == `PPM_OFF_IBUF);
    wire w_hit = w_mode | w_addr | w_data | w_ctrl | w_stat | w_mask
                 | w_obuf | w_ibuf;
    wire [15:0] mode_new = 16'((mode_q & ~wmask[15:0])
                           | (wdata_q[15:0] & wmask[15:0]));

    // starts are refused while a transfer runs or in slave modes
    wire start_wr = w_data & wstrb_q[0] & master & ~busy;
    wire start_rd = w_ctrl & wstrb_q[0] & wdata_q[`PPM_CTRL_RD_BIT]
                    & master & ~busy;

    // read decode and mux
    wire ar_go = s_axi_arvalid & s_axi_arready;
    wire r_stat = ar_go & (s_axi_araddr == `PPM_OFF_STAT);
    logic [31:0] r_mux;
    logic r_hit;
    always_comb begin
        r_hit = 1'b1;
        case (s_axi_araddr)
            `PPM_OFF_MODE: r_mux = {16'h0000, busy, mode_q[14:11], 1'b0,
                                    mode_q[9:0]};
            `PPM_OFF_ADDR: r_mux = {17'h00000, port_address_lines_o};
            `PPM_OFF_DATA: r_mux = {24'h000000, rd_data};
            `PPM_OFF_CTRL: r_mux = {30'h00000000, a14_cs, 1'b0};
            `PPM_OFF_STAT: r_mux = {30'h00000000, stat};
            `PPM_OFF_MASK: r_mux = {30'h00000000, mask};
            `PPM_OFF_OBUF: r_mux = {obuf[3], obuf[2], obuf[1], obuf[0]};
            `PPM_OFF_IBUF: r_mux = {ibuf[3], ibuf[2], ibuf[1], ibuf[0]};
            default: begin
                r_mux = 32'h00000000;
                r_hit = 1'b0;
            end
        endcase
    end

    // axi write channels, each ready drops until the response is taken
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PPM_RESP_OK;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= w_hit ? `PPM_RESP_OK : `PPM_RESP_ERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // axi read channel, answer one cycle after the address
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PPM_RESP_OK;
        end else if (ar_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= r_mux;
            s_axi_rresp <= r_hit ? `PPM_RESP_OK : `PPM_RESP_ERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // phase lengths; strobe field zero overrides setup and hold
    wire wm0 = (m.strobe_wait_count == 4'h0);
    wire [2:0] setup_len = wm0 ? `PPM_SETUP_FORCED
                         : {1'b0, m.setup_wait_count} + 3'h1;
    wire [2:0] hold_len = !wm0 ? {1'b0, m.hold_wait_count} + 3'h1
                        : is_rd ? `PPM_HOLD_RD_FORCED
                        : `PPM_HOLD_WR_FORCED;

    // master sequencer: setup, strobe, hold
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        done = 1'b0;
        case (state)
            ppm_pkg::PPM_IDLE: begin
                if (start_wr || start_rd) begin
                    next_state = ppm_pkg::PPM_SETUP;
                    next_cnt = {1'b0, setup_len - 3'h1};
                end
            end
            ppm_pkg::PPM_SETUP: begin
                if (cnt == 4'h0) begin
                    next_state = ppm_pkg::PPM_STROBE;
                    next_cnt = m.strobe_wait_count;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            ppm_pkg::PPM_STROBE: begin
                if (cnt != 4'h0) begin
                    next_cnt = cnt - 4'h1;
                end else if (hold_len == 3'h0) begin
                    next_state = ppm_pkg::PPM_IDLE;
                    done = 1'b1;
                end else begin
                    next_state = ppm_pkg::PPM_HOLD;
                    next_cnt = {1'b0, hold_len - 3'h1};
                end
            end
            ppm_pkg::PPM_HOLD: begin
                if (cnt == 4'h0) begin
                    next_state = ppm_pkg::PPM_IDLE;
                    done = 1'b1;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            default: next_state = ppm_pkg::PPM_IDLE;
        endcase
    end

    // address stepping; bit 14 joins the count unless it is a select
    wire [14:0] a = port_address_lines_o;
    wire [9:0] seq_up = {a[14], a[10:2]} + 10'h001;
    wire [9:0] seq_dn = {a[14], a[10:2]} - 10'h001;
    wire [8:0] low_up = a[10:2] + 9'h001;
    wire [8:0] low_dn = a[10:2] - 9'h001;
    wire [14:0] up_addr = a14_cs ? {a[14:11], low_up, a[1:0]}
                        : {seq_up[9], a[13:11], seq_up[8:0], a[1:0]};
    wire [14:0] dn_addr = a14_cs ? {a[14:11], low_dn, a[1:0]}
                        : {seq_dn[9], a[13:11], seq_dn[8:0], a[1:0]};
    wire [14:0] step_addr = (m.addr_step_mode == 2'b01) ? up_addr
                          : (m.addr_step_mode == 2'b10) ? dn_addr
                          : a;

    // slave side: host writes are taken at the strobe's leading edge, reads are driven while the strobe is held
    wire acc = ~master & host_i.chip_select_one
               & (host_i.read_strobe | host_i.write_strobe);
    wire acc_start = acc & ~acc_prev;
    wire acc_end = ~acc & acc_prev;
    wire legacy_buf = (m.port_mode == 2'b00) & (m.addr_step_mode == 2'b11);
    wire [1:0] idx = (m.port_mode == 2'b01) ? host_i.port_address
                   : !legacy_buf ? 2'b00
                   : host_i.read_strobe ? rd_ptr : wr_ptr;
    wire s_wr = acc_start & host_i.write_strobe;
    wire s_rdlvl = acc & host_i.read_strobe;

    // interrupt events per irq mode; 11 is reserved and stays silent
    wire ev_end = (m.irq_mode_sel == 2'b01) & (done | acc_end);
    wire ev_buf = (m.irq_mode_sel == 2'b10) & acc_start
                  & (idx == `PPM_LAST_BUF)
                  & ((m.port_mode == 2'b01) | legacy_buf);
    wire irq_evt = ev_end | ev_buf;
    wire [1:0] ev = {done, irq_evt};

    // sequencer state, address register, mode and control registers
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= ppm_pkg::PPM_IDLE;
            cnt <= 4'h0;
            is_rd <= 1'b0;
            mode_q <= `PPM_MODE_RST;
            a14_cs <= 1'b0;
            port_address_lines_o <= 15'h0000;
            wr_data <= 8'h00;
            rd_data <= 8'h00;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            if (start_wr || start_rd)
                is_rd <= start_rd;
            if (w_mode)
                mode_q <= mode_new & `PPM_MODE_WMASK;
            if (w_ctrl && wstrb_q[0])
                a14_cs <= wdata_q[`PPM_CTRL_A14_BIT];
            if (start_wr)
                wr_data <= wdata_q[7:0];
            if (state == ppm_pkg::PPM_STROBE && cnt == 4'h0 && is_rd)
                rd_data <= port_data_bus_i;
            // hardware step wins over a software address write
            if (done)
                port_address_lines_o <= step_addr;
            else if (w_addr)
                port_address_lines_o <= 15'((a & ~wmask[14:0])
                                        | (wdata_q[14:0] & wmask[14:0]));
        end
    end

    // pins follow the next state so they line up with the phases
    wire n_busy = (next_state != ppm_pkg::PPM_IDLE);
    wire n_strb = (next_state == ppm_pkg::PPM_STROBE);
    wire n_rd = (start_wr | start_rd) ? start_rd : is_rd;
    wire mode1 = (m.port_mode == 2'b11);
    // new byte shows from the first setup cycle, not one cycle late
    wire [7:0] n_wdata = start_wr ? wdata_q[7:0] : wr_data;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            chip_select_one_o <= 1'b0;
            read_strobe_o <= 1'b0;
            write_strobe_o <= 1'b0;
            enable_strobe_o <= 1'b0;
            port_data_bus_o <= 8'h00;
            port_data_bus_oe_o <= 1'b0;
        end else begin
            chip_select_one_o <= n_busy;
            read_strobe_o <= mode1 ? n_busy & n_rd
                           : n_strb & n_rd;
            write_strobe_o <= ~mode1 & n_strb & ~n_rd;
            enable_strobe_o <= mode1 & n_strb;
            port_data_bus_oe_o <= (n_busy & ~n_rd) | s_rdlvl;
            port_data_bus_o <= s_rdlvl ? obuf[idx]
                             : (n_busy & ~n_rd) ? n_wdata : 8'h00;
        end
    end

    // slave pointers advance when the access ends
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            acc_prev <= 1'b0;
            last_rd <= 1'b0;
            rd_ptr <= 2'b00;
            wr_ptr <= 2'b00;
        end else begin
            acc_prev <= acc;
            if (acc_start)
                last_rd <= host_i.read_strobe;
            if (acc_end && legacy_buf && last_rd)
                rd_ptr <= rd_ptr + 2'b01;
            if (acc_end && legacy_buf && !last_rd)
                wr_ptr <= wr_ptr + 2'b01;
        end
    end

    // byte buffers: software fills outgoing, host fills incoming
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_buf
            always_ff @(posedge clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    obuf[gi] <= 8'h00;
                    ibuf[gi] <= 8'h00;
                end else begin
                    if (w_obuf && wstrb_q[gi])
                        obuf[gi] <= wdata_q[8*gi +: 8];
                    if (s_wr && idx == 2'(gi))
                        ibuf[gi] <= port_data_bus_i;
                end
            end
        end
    endgenerate

    // sticky status, read clears, a new event wins over the clear
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            stat <= 2'b00;
            mask <= 2'b00;
            irq_o <= 1'b0;
        end else begin
            stat <= (stat & ~{2{r_stat}}) | ev;
            if (w_mask && wstrb_q[0])
                mask <= wdata_q[1:0];
            irq_o <= |(stat & mask);
        end
    end

    // helper: run length of the write strobe
    logic [4:0] wr_run;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n)
            wr_run <= 5'h00;
        else
            wr_run <= write_strobe_o ? wr_run + 5'h01 : 5'h00;
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n);

    a_busy_start: assert property ((start_wr || start_rd)
        |=> busy ##0 chip_select_one_o)
        else $error("busy not raised at transfer start");
    a_end_irq: assert property (done && m.irq_mode_sel == 2'b01
        |=> stat[`PPM_ST_EVT_BIT])
        else $error("no event at cycle end");
    a_buf3_irq: assert property (acc_start && m.port_mode == 2'b01
        && m.irq_mode_sel == 2'b10 && host_i.port_address == 2'b11
        |=> stat[`PPM_ST_EVT_BIT])
        else $error("no event on buffer three");
    a_irq_quiet: assert property (m.irq_mode_sel == 2'b00 |-> !irq_evt)
        else $error("event with irq mode off");
    a_addr_inc: assert property (done && m.addr_step_mode == 2'b01
        && !a14_cs |=> port_address_lines_o[10:2]
        == 9'($past(port_address_lines_o[10:2]) + 9'h001))
        else $error("address not incremented");
    // the cast wraps, so a count at zero is checked as well
    a_addr_dec: assert property (done && m.addr_step_mode == 2'b10
        && !a14_cs |=> port_address_lines_o[10:2]
        == 9'($past(port_address_lines_o[10:2]) - 9'h001))
        else $error("address not decremented");
    a_addr_keep: assert property (done && m.addr_step_mode == 2'b00
        |=> $stable(port_address_lines_o))
        else $error("address moved with stepping off");
    a_a14_fixed: assert property (done && a14_cs
        |=> $stable(port_address_lines_o[14]))
        else $error("select bit stepped");
    a_ptr_step: assert property (acc_end && legacy_buf && !last_rd
        |=> wr_ptr == 2'($past(wr_ptr) + 2'b01))
        else $error("write pointer not advanced");
    a_strobe_len: assert property ($fell(write_strobe_o) && !mode1
        && $stable(mode_q) |-> wr_run == {1'b0, m.strobe_wait_count}
        + 5'h01)
        else $error("write strobe length wrong");
    a_zero_bits: assert property (mode_q[10] == 1'b0
        && mode_q[`PPM_BUSY_BIT] == 1'b0)
        else $error("reserved mode bits set");

    c_master_wr: cover property (start_wr ##[1:40] done);
    c_master_rd: cover property (start_rd ##[1:40] done);
    c_slave_buf: cover property (ev_buf);
    c_irq: cover property ($rose(irq_o));

endmodule // ppm_ctrl
`default_nettype wire

// [design/ppm_defs.svh]
// Purpose: offsets, field positions, reset values, timing counts
// Assumes: 32-bit AXI4-Lite register words, 8-bit byte addresses
// Notes: definitions only
`ifndef PPM_DEFS_SVH
`define PPM_DEFS_SVH
`define PPM_AW 8
`define PPM_OFF_MODE 8'h00
`define PPM_OFF_ADDR 8'h04
`define PPM_OFF_DATA 8'h08
`define PPM_OFF_CTRL 8'h0C
`define PPM_OFF_STAT 8'h10
`define PPM_OFF_MASK 8'h14
`define PPM_OFF_OBUF 8'h18
`define PPM_OFF_IBUF 8'h1C
`define PPM_MODE_RST 16'h0000
`define PPM_MODE_WMASK 16'h7BFF
`define PPM_BUSY_BIT 15
`define PPM_CTRL_RD_BIT 0
`define PPM_CTRL_A14_BIT 1
`define PPM_ST_EVT_BIT 0
`define PPM_ST_DONE_BIT 1
`define PPM_RESP_OK 2'b00
`define PPM_RESP_ERR 2'b10
`define PPM_LAST_BUF 2'h3
`define PPM_SETUP_FORCED 3'h1
`define PPM_HOLD_WR_FORCED 3'h1
`define PPM_HOLD_RD_FORCED 3'h0
`endif

// [design/ppm_pkg.sv]
// Purpose: shared types of the parallel port mode control
// Assumes: nothing
// Notes: field order matches the mode register bits 14..0
package ppm_pkg;
    typedef enum logic [1:0] {
        PPM_IDLE = 2'b00,
        PPM_SETUP = 2'b01,
        PPM_STROBE = 2'b10,
        PPM_HOLD = 2'b11
    } ppm_state_t;
    typedef struct packed {
        logic [1:0] irq_mode_sel;
        logic [1:0] addr_step_mode;
        logic unused;
        logic [1:0] port_mode;
        logic [1:0] setup_wait_count;
        logic [3:0] strobe_wait_count;
        logic [1:0] hold_wait_count;
    } ppm_mode_t;
    typedef struct packed {
        logic chip_select_one;
        logic read_strobe;
        logic write_strobe;
        logic [1:0] port_address;
    } ppm_host_t;
endpackage

// [verification/ppm_far_model.sv]
// Purpose: external byte peripheral facing the master port pins
// Assumes: active-high strobes, mode 11 direction high means read
// Notes: released data bus toggles between 8'h5A and 8'hA5, so it equals RD_BYTE every other cycle
`timescale 1ns/1ps
`default_nettype none
module ppm_far_model #(
    parameter logic [7:0] RD_BYTE = 8'hA5
) (
    input wire logic clk_i,
    input wire logic cs_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic en_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic [7:0] last_wr_o
);
    logic [7:0] junk = 8'h5A;
    wire logic drive = cs_i & rd_i;
    // answer reads while selected, junk otherwise
    assign data_o = drive ? RD_BYTE : junk;
    // capture write byte on either strobe style
    always @(posedge clk_i) begin
        junk <= ~junk;
        if (cs_i & (wr_i | (en_i & ~rd_i))) begin
            last_wr_o <= data_i;
        end
    end
endmodule // ppm_far_model
`default_nettype wire

// [verification/testbench.sv]
// Purpose: self-checking bench for the parallel port mode control
// Assumes: a set mask bit enables the matching status bit
// Notes: host side of the slave modes is driven here
`timescale 1ns/1ps
`default_nettype none
`include "ppm_defs.svh"
`define TB_CHK(g, e) begin n_checks++; if ((g) !== (e)) begin \
    $display("wrong value at %0t: %0h vs %0h", $time, g, e); \
    bad_count++; end end
module testbench;
    typedef struct packed {
        logic [1:0] md, su; logic [3:0] sw; logic [1:0] hd; logic r;
    } ppm_row_t;
    logic clk_i = 0, resetn_i = 0, awv = 0, wv = 0, bre = 0, arv = 0;
    logic rre = 0, hdrv = 0, a14 = 0, awr, wrd, bv, arr, rv, oe, cs;
    logic rs, ws, es, irq;
    logic [7:0] awa = 0, ara = 0, hdata = 0, pdo, far, last_wr;
    logic [31:0] wdata = 0, rdata, rd;
    logic [1:0] bresp, rresp, resp;
    logic [14:0] pa;
    logic [3:0] cfg = 0;
    logic [32:0] steps[5];
    ppm_row_t rows[6];
    ppm_pkg::ppm_host_t host = '0;
    int bad_count = 0, n_checks = 0, cyc = 0, n_cs, n_rd, n_wr, n_en;
    // bus level: block, then host, then peripheral
    wire logic [7:0] pdi = oe ? pdo : (hdrv ? hdata : far);
    always #12.5 clk_i = ~clk_i;
    ppm_ctrl dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rre), .host_i(host),
        .port_data_bus_i(pdi), .port_data_bus_o(pdo),
        .port_data_bus_oe_o(oe), .port_address_lines_o(pa),
        .chip_select_one_o(cs), .read_strobe_o(rs), .write_strobe_o(ws),
        .enable_strobe_o(es), .irq_o(irq));
    ppm_far_model far_dev (.clk_i(clk_i), .cs_i(cs), .rd_i(rs),
        .wr_i(ws), .en_i(es), .data_i(pdo), .data_o(far),
        .last_wr_o(last_wr));
    // pin cycle counters and hang guard
    always @(posedge clk_i) begin
        cyc++;
        n_cs += cs; n_rd += rs; n_wr += ws; n_en += es;
        if (cyc == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        awa <= a; wdata <= d; awv <= 1; wv <= 1; bre <= 1;
        do begin
            @(posedge clk_i);
            if (awr) awv <= 0;
            if (wrd) wv <= 0;
        end while (!bv);
        resp = bresp;
        bre <= 0;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge clk_i);
        ara <= a; arv <= 1; rre <= 1;
        do begin
            @(posedge clk_i);
            if (arr) arv <= 0;
        end while (!rv);
        rd = rdata;
        resp = rresp;
        rre <= 0;
    endtask
    task automatic idle();
        int i;
        i = 0;
        while (cs !== 1'b0 && i < 40) begin
            @(posedge clk_i);
            i++;
        end
        repeat (2) @(posedge clk_i);
    endtask
    function automatic logic [31:0] mw(input logic [1:0] md, su,
            input logic [3:0] sw, input logic [1:0] hd);
        return {17'h0, cfg, 1'b0, md, su, sw, hd};
    endfunction
    // one master transfer with its cycle counts checked
    task automatic mx(input ppm_row_t w);
        int s, m, h;
        s = (w.sw == 0) ? 1 : w.su + 1;
        m = w.sw + 1;
        h = (w.sw != 0) ? w.hd + 1 : (w.r ? 0 : 1);
        axw(`PPM_OFF_MODE, mw(w.md, w.su, w.sw, w.hd));
        n_cs = 0; n_rd = 0; n_wr = 0; n_en = 0;
        if (w.r) axw(`PPM_OFF_CTRL, {30'h0, a14, 1'b1});
        else axw(`PPM_OFF_DATA, 32'h3C);
        idle();
        `TB_CHK(n_cs, s + m + h)
        `TB_CHK(w.md[0] ? n_en : (w.r ? n_rd : n_wr), m)
        if (w.md[0])
            `TB_CHK(n_wr + (w.r ? n_rd : 0), w.r ? s + m + h : 0)
        if (w.r) begin
            axr(`PPM_OFF_DATA);
            `TB_CHK(rd[7:0], 8'hA5)
        end else `TB_CHK(last_wr, 8'h3C)
    endtask
    // host access on the slave pins
    task automatic hacc(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_i);
        host <= '{1'b1, 1'b0, 1'b1, a};
        hdata <= d;
        hdrv <= 1;
        repeat (2) @(posedge clk_i);
        host <= '0;
        hdrv <= 0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic finish_test();
        if (bad_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        rows = '{'{2'b10, 2'd0, 4'd1, 2'd0, 1'b0},
            '{2'b10, 2'd3, 4'd2, 2'd2, 1'b1},
            '{2'b11, 2'd1, 4'd0, 2'd3, 1'b0},
            '{2'b11, 2'd2, 4'd0, 2'd1, 1'b1},
            '{2'b11, 2'd0, 4'd15, 2'd0, 1'b0},
            '{2'b10, 2'd2, 4'd0, 2'd3, 1'b0}};
        steps = '{{2'b01, 1'b0, 15'h07FC, 15'h4000},
            {2'b10, 1'b0, 15'h4000, 15'h07FC},
            {2'b00, 1'b0, 15'h0124, 15'h0124},
            {2'b01, 1'b1, 15'h47FC, 15'h4000},
            {2'b10, 1'b1, 15'h0000, 15'h07FC}};
        repeat (3) @(posedge clk_i);
        resetn_i <= 1;
        repeat (3) @(posedge clk_i);
        axr(`PPM_OFF_MODE);
        `TB_CHK(rd, 32'h0)
        foreach (rows[i]) mx(rows[i]);
        // read-only and unimplemented bits, unmapped place
        axw(`PPM_OFF_MODE, 32'hFFFF_DFFF);
        axr(`PPM_OFF_MODE);
        `TB_CHK(rd, 32'h0000_5BFF)
        axw(8'h20, 32'h1);
        `TB_CHK(resp, `PPM_RESP_ERR)
        axr(8'h20);
        `TB_CHK({resp, rd}, {`PPM_RESP_ERR, 32'h0})
        // activity flag during a long strobe
        cfg = 0;
        axw(`PPM_OFF_MODE, mw(2'b10, 2'd0, 4'd15, 2'd0));
        axw(`PPM_OFF_DATA, 32'h1);
        axr(`PPM_OFF_MODE);
        `TB_CHK(rd[15], 1'b1)
        idle();
        axr(`PPM_OFF_MODE);
        `TB_CHK(rd[15], 1'b0)
        // address stepping, with and without bit 14 as select
        foreach (steps[i]) begin
            a14 = steps[i][30];
            axw(`PPM_OFF_CTRL, {30'h0, a14, 1'b0});
            axw(`PPM_OFF_ADDR, {17'h0, steps[i][29:15]});
            cfg = {2'b00, steps[i][32:31]};
            mx(rows[0]);
            `TB_CHK(pa, steps[i][14:0])
        end
        // interrupt raised, silenced, masked, cleared
        axw(`PPM_OFF_MASK, 32'h1);
        for (int k = 0; k < 3; k++) begin
            cfg = (k == 1) ? 4'b0000 : 4'b0100;
            if (k == 2) axw(`PPM_OFF_MASK, 32'h0);
            mx(rows[0]);
            `TB_CHK(irq, k == 0)
            axr(`PPM_OFF_STAT);
            `TB_CHK(rd[1:0], (k == 1) ? 2'b10 : 2'b11)
        end
        repeat (2) @(posedge clk_i);
        `TB_CHK(irq, 1'b0)
        axw(`PPM_OFF_MASK, 32'h1);
        cfg = 4'b1000;
        axw(`PPM_OFF_MODE, mw(2'b01, 2'd0, 4'd0, 2'd0));
        hacc(2'b01, 8'h11);
        axr(`PPM_OFF_STAT);
        `TB_CHK(rd[0], 1'b0)
        hacc(2'b11, 8'h22);
        `TB_CHK(irq, 1'b1)
        axr(`PPM_OFF_STAT);
        `TB_CHK(rd[0], 1'b1)
        // legacy buffered slave fills four buffers
        cfg = 4'b1011;
        axw(`PPM_OFF_MODE, mw(2'b00, 2'd0, 4'd0, 2'd0));
        for (int k = 0; k < 4; k++) begin
            hacc(2'b00, 8'(8'h40 + k));
            axr(`PPM_OFF_STAT);
            `TB_CHK(rd[0], k == 3)
        end
        axr(`PPM_OFF_IBUF);
        `TB_CHK(rd, 32'h4342_4140)
        // enhanced slave read serves the addressed outgoing byte
        axw(`PPM_OFF_OBUF, 32'h8877_6655);
        axw(`PPM_OFF_MODE, mw(2'b01, 2'd0, 4'd0, 2'd0));
        @(posedge clk_i);
        host <= '{1'b1, 1'b1, 1'b0, 2'b10};
        repeat (2) @(posedge clk_i);
        `TB_CHK({oe, pdo}, 9'h177)
        host <= '0;
        finish_test();
    end
endmodule // testbench
`default_nettype wire
